// ### include/odc_pkg.sv
`default_nettype none

package odc_pkg;

   // Card configurations, port roles, client kinds and trunk line rates.
   typedef enum logic [2:0] {CFG_TXP, CFG_STD_REGEN, CFG_ENH_REGEN, CFG_LAN_WAN, CFG_SPLIT_PROT} cfg_e;
   typedef enum logic [1:0] {ROLE_UNUSED, ROLE_CLIENT, ROLE_TRUNK} role_e;
   typedef enum logic [1:0] {CL_SONET, CL_LAN, CL_FC, CL_FIVE_GIG_DOUBLE_RATE} client_e;
   typedef enum logic [2:0] {RATE_OTU2, RATE_OTU2E_NFS, RATE_OTU2E_FS, RATE_FC_OC, RATE_PROP} rate_e;

   // Number of legal configuration codes.
   localparam logic [2:0] CFG_COUNT = 3'h5;

   // Register byte offsets.
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_FEC = 8'h04;
   localparam logic [7:0] OFS_CLIENT = 8'h08;
   localparam logic [7:0] OFS_MTU = 8'h0C;
   localparam logic [7:0] OFS_CREATE = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_OVSZ = 8'h18;
   localparam logic [7:0] OFS_RUNT = 8'h1C;

   // Field positions.
   localparam int CFG_NFS_BIT = 4;
   localparam int CLIENT_CH1_LSB = 4;
   localparam int STAT_REJ_BIT = 0;

   // Reset values and frame limits.
   localparam logic [15:0] MTU_RST = 16'h05EE;
   localparam logic [15:0] FRAME_MIN = 16'h0040;
   localparam logic [3:0] CREATED_RST = 4'hF;

   // Standard Reed-Solomon codeword, total and data symbols.
   localparam logic [7:0] RS_N = 8'hFF;
   localparam logic [7:0] RS_K = 8'hEF;

   // Client frame event: channel and length in bytes.
   typedef struct packed {
      logic vld;
      logic ch;
      logic [15:0] len;
   } frm_s;

   // Card state that drives the optics and framers.
   typedef struct packed {
      role_e [3:0] role;
      logic [3:0] enhanced_error_correction;
      logic [3:0] rs_std;
      logic [3:0] otu_frm;
      logic [3:0] created;
      rate_e [1:0] rate;
      logic lan_wan;
      logic nfs;
      logic [1:0] ycab_ok;
      logic [1:0] odu1_mux;
   } stat_s;

endpackage : odc_pkg

`default_nettype wire

// ### rtl/odc_port_config.sv
// Behaviour
// - Transponder and LAN-to-WAN make ports 1,2 clients; split-protected only port 1.
// - Transponder, LAN-to-WAN and split-protected make ports 3,4 trunks.
// - Standard regenerator makes all four ports OTU2 trunks.
// - Enhanced regenerator uses ports 3,4 as trunks, ports 1,2 unused.
// - Split-protected trunks 3 and 4 each take either FEC independently.
// - Reset brings transponder configuration with standard FEC on both trunks.
// - In transponder or standard regenerator, creating one port creates its pair.
// - Regenerator allows enhanced FEC only on ports 3,4; ports 1,2 standard.
// - Entering standard regenerator defaults ports 3,4 to standard FEC.
// - Entering enhanced regenerator defaults ports 3,4 to enhanced FEC.
// - Trunk line rate does not depend on the FEC mode.
// - Standard mode applies Reed-Solomon 255/239 trunk coding.
// - Enhanced mode keeps transport unit framing, gain above 8 dB.
// - Ethernet clients accept 64-byte minimum frames; maximum size is provisionable.
// - Fixed/no-fixed stuff selection only acts in transponder configuration.
// - LAN-to-WAN conversion acts on the first channel only.
// - No Y-cable protection on the converted pair.
// - SONET or WAN clients use the 10.70923 Gbps trunk rate.
// - LAN clients use 11.0491 Gbps with no-fixed-stuff, else 11.0957 Gbps.
// - Fibre Channel clients use the 11.3168 Gbps overclocked rate.
// - Frames up to 65535 bytes pass; size limit only counts oversize.
// - Regenerator configurations pass ODU1-multiplexed OTU2 signals.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module odc_port_config (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Client frame events and trunk forwarding.
   input wire odc_pkg::frm_s frm_i,
   output odc_pkg::frm_s fwd_o,
   // Card state.
   output odc_pkg::stat_s stat_o
);

   // Role of one port under a given configuration.
   function automatic odc_pkg::role_e role_f(input odc_pkg::cfg_e cfg, input int idx);
      odc_pkg::role_e r;
      r = odc_pkg::ROLE_TRUNK;
      case (cfg)
         odc_pkg::CFG_TXP, odc_pkg::CFG_LAN_WAN: begin
            r = (idx < 2) ? odc_pkg::ROLE_CLIENT : odc_pkg::ROLE_TRUNK;
         end
         odc_pkg::CFG_STD_REGEN: begin
            r = odc_pkg::ROLE_TRUNK;
         end
         odc_pkg::CFG_ENH_REGEN: begin
            r = (idx < 2) ? odc_pkg::ROLE_UNUSED : odc_pkg::ROLE_TRUNK;
         end
         odc_pkg::CFG_SPLIT_PROT: begin
            r = (idx == 0) ? odc_pkg::ROLE_CLIENT : (idx == 1) ? odc_pkg::ROLE_UNUSED : odc_pkg::ROLE_TRUNK;
         end
         default: begin
            r = odc_pkg::ROLE_TRUNK;
         end
      endcase
      return r;
   endfunction : role_f

   // Trunk line rate for a client kind; FEC mode is not an input.
   function automatic odc_pkg::rate_e rate_f(input odc_pkg::client_e cl, input logic nfs);
      odc_pkg::rate_e r;
      r = odc_pkg::RATE_OTU2;
      case (cl)
         odc_pkg::CL_SONET: begin
            r = odc_pkg::RATE_OTU2;
         end
         odc_pkg::CL_LAN: begin
            r = nfs ? odc_pkg::RATE_OTU2E_NFS : odc_pkg::RATE_OTU2E_FS;
         end
         odc_pkg::CL_FC: begin
            r = odc_pkg::RATE_FC_OC;
         end
         default: begin
            r = odc_pkg::RATE_PROP;
         end
      endcase
      return r;
   endfunction : rate_f

   // Software-held state.
   odc_pkg::cfg_e cfg_reg;
   logic nfs_reg;
   logic [3:0] fec_reg;
   odc_pkg::client_e [1:0] client_reg;
   logic [15:0] mtu_reg;
   logic [3:0] created_reg;
   logic rej_reg;
   logic [15:0] ovsz_reg;
   logic [15:0] runt_reg;
   logic [31:0] rdata_reg;
   odc_pkg::frm_s fwd_reg;
   odc_pkg::stat_s stat_reg;

   // Next values.
   odc_pkg::cfg_e cfg_next;
   logic [3:0] fec_next;
   logic [3:0] created_next;
   odc_pkg::stat_s stat_next;
   logic [31:0] rdata_next;

   // Write decode.
   wire wr_cfg = wr_i && (addr_i == odc_pkg::OFS_CFG);
   wire wr_fec = wr_i && (addr_i == odc_pkg::OFS_FEC);
   wire wr_client = wr_i && (addr_i == odc_pkg::OFS_CLIENT);
   wire wr_mtu = wr_i && (addr_i == odc_pkg::OFS_MTU);
   wire wr_create = wr_i && (addr_i == odc_pkg::OFS_CREATE);
   wire wr_stat = wr_i && (addr_i == odc_pkg::OFS_STAT);
   wire cfg_ok = wdata_i[2:0] < odc_pkg::CFG_COUNT;
   wire odc_pkg::cfg_e cfg_wr = odc_pkg::cfg_e'(wdata_i[2:0]);

   // Configuration classes.
   wire is_txp = cfg_reg == odc_pkg::CFG_TXP;
   wire is_regen = (cfg_reg == odc_pkg::CFG_STD_REGEN) || (cfg_reg == odc_pkg::CFG_ENH_REGEN);
   wire is_lan_wan = cfg_reg == odc_pkg::CFG_LAN_WAN;
   wire fec_rej = wr_fec && is_regen && (wdata_i[1:0] != 2'h0);

   // New configuration is taken only for a legal code.
   assign cfg_next = (wr_cfg && cfg_ok) ? cfg_wr : cfg_reg;

   // FEC selection with defaults on a configuration change.
   always_comb begin
      fec_next = fec_reg;
      if (wr_cfg && cfg_ok) begin
         case (cfg_wr)
            odc_pkg::CFG_STD_REGEN: begin
               fec_next = 4'h0;
            end
            odc_pkg::CFG_ENH_REGEN: begin
               fec_next = 4'hC;
            end
            default: begin
               fec_next = {fec_reg[3:2], 2'h0};
            end
         endcase
      end else if (wr_fec && !fec_rej) begin
         fec_next = {wdata_i[3:2], is_regen ? 2'h0 : 2'h0};
      end
   end

   wire pair_mode = is_txp || is_regen;
   wire [3:0] create_req = wdata_i[3:0] | (pair_mode ? {wdata_i[1:0], wdata_i[3:2]} : 4'h0);
   always_comb begin
      created_next = created_reg;
      if (wr_cfg && cfg_ok) begin
         created_next = (cfg_wr == odc_pkg::CFG_ENH_REGEN) ? {created_reg[3:2], 2'h0} : created_reg;
      end else if (wr_create) begin
         created_next = created_reg | create_req;
         if (cfg_reg == odc_pkg::CFG_ENH_REGEN) begin
            created_next[1:0] = 2'h0;
         end
      end
   end

   // Port roles, one decode per port.
   generate
      for (genvar p = 0; p < 4; p++) begin : g_port
         assign stat_next.role[p] = role_f(cfg_reg, p);
         assign stat_next.rs_std[p] = (stat_next.role[p] == odc_pkg::ROLE_TRUNK) && !fec_reg[p];
         assign stat_next.otu_frm[p] = stat_next.role[p] == odc_pkg::ROLE_TRUNK;
      end
   endgenerate

   wire nfs_eff = nfs_reg && is_txp;

   // Remaining card state.
   assign stat_next.enhanced_error_correction = fec_reg;
   assign stat_next.created = created_reg;
   assign stat_next.lan_wan = is_lan_wan;
   assign stat_next.nfs = nfs_eff;
   assign stat_next.rate[0] = is_lan_wan ? odc_pkg::RATE_OTU2 : rate_f(client_reg[0], nfs_eff);
   assign stat_next.rate[1] = rate_f(client_reg[1], nfs_eff);
   assign stat_next.ycab_ok = {1'b1, !is_lan_wan};
   assign stat_next.odu1_mux = {2{is_regen}};

   // Frame checks against fixed minimum and provisioned maximum.
   wire frm_runt = frm_i.vld && (frm_i.len < odc_pkg::FRAME_MIN);
   wire frm_ovsz = frm_i.vld && (frm_i.len > mtu_reg);

   // Read data multiplexer.
   always_comb begin
      rdata_next = 32'h0;
      case (addr_i)
         odc_pkg::OFS_CFG: begin
            rdata_next = {27'h0, nfs_reg, 1'b0, cfg_reg};
         end
         odc_pkg::OFS_FEC: begin
            rdata_next = {28'h0, fec_reg};
         end
         odc_pkg::OFS_CLIENT: begin
            rdata_next = {26'h0, client_reg[1], 2'h0, client_reg[0]};
         end
         odc_pkg::OFS_MTU: begin
            rdata_next = {16'h0, mtu_reg};
         end
         odc_pkg::OFS_CREATE: begin
            rdata_next = {28'h0, created_reg};
         end
         odc_pkg::OFS_STAT: begin
            rdata_next = {31'h0, rej_reg};
         end
         odc_pkg::OFS_OVSZ: begin
            rdata_next = {16'h0, ovsz_reg};
         end
         odc_pkg::OFS_RUNT: begin
            rdata_next = {16'h0, runt_reg};
         end
         default: begin
            rdata_next = 32'h0;
         end
      endcase
   end

   // Configuration registers.
   // reset to transponder, standard FEC
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_reg <= odc_pkg::CFG_TXP;
         fec_reg <= 4'h0;
         created_reg <= odc_pkg::CREATED_RST;
         nfs_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         fec_reg <= fec_next;
         created_reg <= created_next;
         if (wr_cfg) begin
            nfs_reg <= wdata_i[odc_pkg::CFG_NFS_BIT];
         end
      end
   end

   // Client kinds and size limit.
   // provisionable maximum
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         client_reg <= '{odc_pkg::CL_SONET, odc_pkg::CL_SONET};
         mtu_reg <= odc_pkg::MTU_RST;
      end else begin
         if (wr_client) begin
            client_reg[0] <= odc_pkg::client_e'(wdata_i[1:0]);
            client_reg[1] <= odc_pkg::client_e'(wdata_i[odc_pkg::CLIENT_CH1_LSB +: 2]);
         end
         if (wr_mtu) begin
            mtu_reg <= wdata_i[15:0];
         end
      end
   end

   // Sticky reject flag; a new reject wins over the clear.
   // sticky reject flag
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rej_reg <= 1'b0;
      end else if (fec_rej) begin
         rej_reg <= 1'b1;
      end else if (wr_stat && wdata_i[odc_pkg::STAT_REJ_BIT]) begin
         rej_reg <= 1'b0;
      end
   end

   // Frame forwarding and counters.
   // forward regardless of limit
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fwd_reg <= '0;
         ovsz_reg <= 16'h0;
         runt_reg <= 16'h0;
      end else begin
         fwd_reg <= frm_i;
         fwd_reg.vld <= frm_i.vld && !frm_runt;
         ovsz_reg <= ovsz_reg + {15'h0, frm_ovsz && !frm_runt};
         runt_reg <= runt_reg + {15'h0, frm_runt};
      end
   end

   // Output registers.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_reg <= 32'h0;
         stat_reg <= '0;
      end else begin
         rdata_reg <= rd_i ? rdata_next : 32'h0;
         stat_reg <= stat_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign fwd_o = fwd_reg;
   assign stat_o = stat_reg;

   // Goes high one edge after reset, once stat_o carries a real decode rather than the reset zeros.
   logic prop_live_reg;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prop_live_reg <= 1'b0;
      end else begin
         prop_live_reg <= 1'b1;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   property p_txp_roles;
      prop_live_reg && is_txp |=> stat_o.role[0] == odc_pkg::ROLE_CLIENT && stat_o.role[1] == odc_pkg::ROLE_CLIENT;
   endproperty
   a_txp_roles: assert property (p_txp_roles) else $error("client roles wrong");

   property p_trunk_roles;
      prop_live_reg && (is_txp || is_lan_wan || cfg_reg == odc_pkg::CFG_SPLIT_PROT)
         |=> stat_o.role[2] == odc_pkg::ROLE_TRUNK && stat_o.role[3] == odc_pkg::ROLE_TRUNK;
   endproperty
   a_trunk_roles: assert property (p_trunk_roles) else $error("trunk roles wrong");

   property p_std_regen;
      cfg_reg == odc_pkg::CFG_STD_REGEN |=> stat_o.role == {4{odc_pkg::ROLE_TRUNK}};
   endproperty
   a_std_regen: assert property (p_std_regen) else $error("regen roles wrong");

   property p_enh_unused;
      cfg_reg == odc_pkg::CFG_ENH_REGEN |=> stat_o.role[0] == odc_pkg::ROLE_UNUSED && stat_o.created[1:0] == 2'h0;
   endproperty
   a_enh_unused: assert property (p_enh_unused) else $error("ports 1,2 in use");

   property p_regen_std;
      is_regen |=> stat_o.enhanced_error_correction[1:0] == 2'h0;
   endproperty
   a_regen_std: assert property (p_regen_std) else $error("enhanced on port 1 or 2");

   property p_enh_default;
      wr_cfg && wdata_i[2:0] == 3'h2 |=> fec_reg == 4'hC ##1 stat_o.enhanced_error_correction == 4'hC;
   endproperty
   a_enh_default: assert property (p_enh_default) else $error("enhanced default missing");

   property p_reject;
      fec_rej |=> fec_reg == $past(fec_reg) && rej_reg;
   endproperty
   a_reject: assert property (p_reject) else $error("reject did not hold");

   property p_forward;
      frm_i.vld && frm_i.len >= odc_pkg::FRAME_MIN |=> fwd_o.vld && fwd_o.len == $past(frm_i.len);
   endproperty
   a_forward: assert property (p_forward) else $error("frame not forwarded");

   property p_runt;
      frm_runt |=> !fwd_o.vld && runt_reg == $past(runt_reg) + 16'h1;
   endproperty
   a_runt: assert property (p_runt) else $error("runt mishandled");

   property p_lan_rate;
      is_txp && nfs_reg && client_reg[1] == odc_pkg::CL_LAN |=> stat_o.rate[1] == odc_pkg::RATE_OTU2E_NFS;
   endproperty
   a_lan_rate: assert property (p_lan_rate) else $error("lan rate wrong");

   c_enh_regen: cover property (wr_cfg && wdata_i[2:0] == 3'h2 ##1 is_regen);
   c_reject: cover property (fec_rej ##1 rej_reg);
   c_oversize: cover property (frm_ovsz && !frm_runt ##1 fwd_o.vld);

endmodule : odc_port_config

`default_nettype wire

// ### dv/odc_frame_src.sv
`timescale 1ns/10ps
`default_nettype none

// Client-side source that sends one frame-end event for each request.
module odc_frame_src (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Request from the bench.
   input wire logic send_i,
   input wire logic [15:0] len_i,
   // Frame event towards the card.
   output odc_pkg::frm_s frm_o
);
   // Between frames the fields toggle, so stale values never look like a frame.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         frm_o <= '0;
      end else if (send_i) begin
         frm_o <= {1'b1, 1'b0, len_i};
      end else begin
         frm_o <= {1'b0, ~frm_o.ch, ~frm_o.len};
      end
   end
endmodule : odc_frame_src

`default_nettype wire

// ### dv/odc_port_config_test.sv
`timescale 1ns/10ps
`default_nettype none

module odc_port_config_test;
   logic mclk_i, rstn_i, wr_i, rd_i, send;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, rv;
   logic [15:0] flen;
   odc_pkg::frm_s frm_i, fwd_o;
   odc_pkg::stat_s stat_o;
   int mismatches, total_checks;

   // Free-running 10 MHz clock.
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   odc_port_config DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .frm_i(frm_i), .fwd_o(fwd_o), .stat_o(stat_o));
   odc_frame_src SRC (.mclk_i(mclk_i), .rstn_i(rstn_i), .send_i(send), .len_i(flen), .frm_o(frm_i));

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One write cycle, then wait until the card state shows it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      @(posedge mclk_i);
      #1;
   endtask : wr

   // One read cycle; the data stand only in the following cycle.
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      rv = rdata_o;
   endtask : rd

   // One frame through the source, judged one cycle after the source takes it.
   task automatic frame(input logic [15:0] l, input logic v);
      @(posedge mclk_i);
      send <= 1'b1;
      flen <= l;
      @(posedge mclk_i);
      send <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk("fwd_vld", 32'(v), 32'(fwd_o.vld));
      if (v) chk("fwd_len", 32'(l), 32'(fwd_o.len));
      if (v) chk("fwd_ch", 32'h0, 32'(fwd_o.ch));
   endtask : frame

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // State and registers straight after reset.
   task automatic test_reset;
      chk("role", 32'hA5, 32'(stat_o.role));
      chk("fec", 32'h0, 32'(stat_o.enhanced_error_correction));
      chk("rate", 32'h0, 32'(stat_o.rate));
      rd(odc_pkg::OFS_CFG);
      chk("cfg", 32'h0, rv);
      rd(odc_pkg::OFS_MTU);
      chk("mtu", 32'(odc_pkg::MTU_RST), rv);
      rd(odc_pkg::OFS_CREATE);
      chk("created", 32'hF, rv);
      rd(8'h40);
      chk("unmapped", 32'h0, rv);
      $display("test reset done");
   endtask : test_reset

   // Every configuration: roles, FEC defaults, framing and pairing flags.
   task automatic test_cfg;
      logic [7:0] role_tab [5];
      logic [3:0] fec_tab [5];
      logic [3:0] tm;
      role_tab = '{8'hA5, 8'hAA, 8'hA0, 8'hA5, 8'hA1};
      fec_tab = '{4'h0, 4'h0, 4'hC, 4'hC, 4'hC};
      for (int c = 0; c < 5; c++) begin
         wr(odc_pkg::OFS_CFG, 32'(c));
         for (int p = 0; p < 4; p++) tm[p] = role_tab[c][2*p+1];
         chk("role", 32'(role_tab[c]), 32'(stat_o.role));
         chk("fec", 32'(fec_tab[c]), 32'(stat_o.enhanced_error_correction));
         chk("framing", 32'(tm), 32'(stat_o.otu_frm));
         chk("rs", 32'(tm & ~fec_tab[c]), 32'(stat_o.rs_std));
         chk("odu1", 32'(c == 1 || c == 2), 32'(stat_o.odu1_mux != 2'h0));
         chk("lanwan", 32'(c == 3), 32'(stat_o.lan_wan));
         if (c == 0 || c == 3) chk("ycab", 32'(c == 0), 32'(stat_o.ycab_ok[0]));
         if (c == 2) chk("enh_created", 32'h0, 32'(stat_o.created[1:0]));
      end
      $display("test cfg done");
   endtask : test_cfg

   // Per-trunk FEC choice and refusal of enhanced FEC on ports 1 and 2.
   task automatic test_fec;
      wr(odc_pkg::OFS_FEC, 32'h4);
      chk("split_fec", 32'h4, 32'(stat_o.enhanced_error_correction));
      wr(odc_pkg::OFS_CFG, 32'h1);
      wr(odc_pkg::OFS_FEC, 32'h1);
      chk("reject_fec", 32'h0, 32'(stat_o.enhanced_error_correction));
      rd(odc_pkg::OFS_STAT);
      chk("reject_flag", 32'h1, rv);
      wr(odc_pkg::OFS_FEC, 32'h8);
      chk("regen_fec", 32'h8, 32'(stat_o.enhanced_error_correction));
      wr(odc_pkg::OFS_STAT, 32'h1);
      rd(odc_pkg::OFS_STAT);
      chk("flag_clear", 32'h0, rv);
      $display("test fec done");
   endtask : test_fec

   // Trunk rate by client kind, stuffing choice and FEC mode.
   task automatic test_rate;
      int cl_tab [4];
      int nfs_tab [4];
      odc_pkg::rate_e rate_tab [4];
      cl_tab = '{0, 1, 1, 2};
      nfs_tab = '{0, 1, 0, 0};
      rate_tab = '{odc_pkg::RATE_OTU2, odc_pkg::RATE_OTU2E_NFS, odc_pkg::RATE_OTU2E_FS, odc_pkg::RATE_FC_OC};
      for (int i = 0; i < 4; i++) begin
         wr(odc_pkg::OFS_CFG, 32'(nfs_tab[i] << odc_pkg::CFG_NFS_BIT));
         wr(odc_pkg::OFS_CLIENT, 32'(cl_tab[i] | (cl_tab[i] << odc_pkg::CLIENT_CH1_LSB)));
         chk("rate0", 32'(rate_tab[i]), 32'(stat_o.rate[0]));
         chk("rate1", 32'(rate_tab[i]), 32'(stat_o.rate[1]));
      end
      wr(odc_pkg::OFS_FEC, 32'hC);
      chk("rate_fec", 32'(odc_pkg::RATE_FC_OC), 32'(stat_o.rate[1]));
      wr(odc_pkg::OFS_CFG, 32'h13);
      wr(odc_pkg::OFS_CLIENT, 32'h11);
      chk("wan_rate0", 32'(odc_pkg::RATE_OTU2), 32'(stat_o.rate[0]));
      chk("wan_rate1", 32'(odc_pkg::RATE_OTU2E_FS), 32'(stat_o.rate[1]));
      chk("nfs", 32'h0, 32'(stat_o.nfs));
      $display("test rate done");
   endtask : test_rate

   // Runt, boundary and oversize frames with their counters.
   task automatic test_frames;
      wr(odc_pkg::OFS_MTU, 32'h64);
      frame(16'h003F, 1'b0);
      frame(16'h0040, 1'b1);
      frame(16'h0064, 1'b1);
      frame(16'hFFFF, 1'b1);
      rd(odc_pkg::OFS_RUNT);
      chk("runt_cnt", 32'h1, rv);
      rd(odc_pkg::OFS_OVSZ);
      chk("ovsz_cnt", 32'h1, rv);
      $display("test frames done");
   endtask : test_frames

   // Creating one port of a pair brings the other port with it.
   task automatic test_create;
      wr(odc_pkg::OFS_CFG, 32'h2);
      wr(odc_pkg::OFS_CFG, 32'h0);
      wr(odc_pkg::OFS_CREATE, 32'h4);
      chk("pair_created", 32'h1, 32'(stat_o.created[0]));
      $display("test create done");
   endtask : test_create

   // Main sequence: reset for 10 cycles, then each scenario in turn.
   initial begin
      rstn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      send = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      flen = 16'h0;
      repeat (10) @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      test_reset();
      test_cfg();
      test_fec();
      test_rate();
      test_frames();
      test_create();
      stop_test();
   end

   // Cuts a hang short and counts it as a mismatch.
   initial begin
      #2000000;
      mismatches++;
      stop_test();
   end
endmodule : odc_port_config_test

`default_nettype wire
